/* File: include/ast_pkg.sv */
package ast_pkg;

    // Register byte offsets on the APB
    localparam logic [11:0] AST_CTRL_OFS   = 12'h000;
    localparam logic [11:0] AST_DATA_OFS   = 12'h004;
    localparam logic [11:0] AST_STATUS_OFS = 12'h008;
    localparam logic [11:0] AST_BAUD_OFS   = 12'h00C;

    // Control register field positions
    localparam int AST_CTRL_TRANSMITTER_ENABLE_BIT   = 0;
    localparam int AST_CTRL_SYNC   = 1;
    localparam int AST_CTRL_SERIAL_PORT_ENABLE   = 2;
    localparam int AST_CTRL_NINE   = 3;
    localparam int AST_CTRL_INV    = 4;
    localparam int AST_CTRL_MASK   = 5;
    localparam int AST_CTRL_BRG16  = 6;
    localparam int AST_CTRL_STOP2  = 7;
    localparam int AST_CTRL_W      = 8;

    // Data register: eight data bits plus the ninth bit
    localparam int AST_DATA_W      = 9;
    localparam int AST_DATA_BIT9   = 8;

    // Status register field positions
    localparam int AST_STAT_EMPTY  = 0;
    localparam int AST_STAT_BUSY   = 1;
    localparam int AST_STAT_LINE   = 2;

    // Reset values
    localparam logic [7:0]  AST_CTRL_RST = 8'h00;
    localparam logic [15:0] AST_BAUD_RST = 16'h0000;
    localparam int          AST_BAUD_W   = 16;

    // Frame shape
    localparam logic [3:0] AST_LAST_BIT8 = 4'h7;
    localparam logic [3:0] AST_LAST_BIT9 = 4'h8;
    localparam logic       AST_MARK      = 1'b1;
    localparam logic       AST_SPACE     = 1'b0;

    // Shifter states, Gray coded along idle-start-data-stop
    typedef enum logic [1:0] {
        AST_IDLE  = 2'b00,
        AST_START = 2'b01,
        AST_DATA  = 2'b11,
        AST_STOP  = 2'b10
    } ast_state_t;

endpackage : ast_pkg

/* File: include/ast_baud_if.sv */
`timescale 1ns/100ps
interface ast_baud_if;
    logic [15:0] divisor;
    logic        brg16;
    logic        restart;
    logic        tick;

    modport gen  (input divisor, input brg16, input restart, output tick);
    modport user (output divisor, output brg16, output restart, input tick);
endinterface : ast_baud_if

/* File: hdl/ast_baud_gen.sv */
`timescale 1ns/100ps
module ast_baud_gen
    import ast_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic ce,
    ast_baud_if.gen   baud
);

    logic [AST_BAUD_W-1:0] count;
    logic [AST_BAUD_W-1:0] eff_div;

    // Eight-bit mode ignores the upper divisor byte
    assign eff_div = baud.brg16 ? baud.divisor
                                : {8'h00, baud.divisor[7:0]};

    // One tick every divisor+1 clocks; restart only reloads the count,
    // since gating the tick with it would loop back through the shifter
    assign baud.tick = (count == '0);

    // Down counter, reloaded on restart or when it runs out
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            count <= AST_BAUD_RST;
        end else if (ce) begin
            if (baud.restart || count == '0) begin
                count <= eff_div;
            end else begin
                count <= count - 16'h0001;
            end
        end
    end

endmodule : ast_baud_gen

/* File: hdl/ast_transmitter.sv */
`timescale 1ns/100ps
// Behaviour
// - Line idles at mark, NRZ between bits
// - Start space, 8/9 data, stop marks
// - Every bit lasts one bit period
// - Data leaves least significant bit first
// - 8 or 16 bit baud divider
// - No parity; ninth bit sent verbatim
// - Shifter hidden, fed only from holding buffer
// - Enable, async select, port enable required
// - Port enable drives the transmit pin
// - Transmitter enable sets buffer-empty flag
// - Idle shifter takes written character immediately
// - Queued character follows stop bit directly
// - Invert select resets low, inverts waveform
// - Inversion applies in async mode only
// - Empty flag clear only when disabled or queued behind busy
// - Empty flag valid second cycle after write
// - Empty flag read-only to software
// - Interrupt request gated by mask only
module ast_transmitter
    import ast_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             transmit_line_pin,
    output logic             transmit_line_oe_n,
    output logic             tx_irq_req
);

    // Software visible configuration
    logic [AST_CTRL_W-1:0] ctrl;
    logic [15:0]           baud_div;

    // Holding buffer and its occupancy
    logic [AST_DATA_W-1:0] tx_holding_buffer;
    logic                  hold_full;

    // Hidden shifter
    logic [AST_DATA_W-1:0] tx_shift_reg;
    logic [3:0]            bit_cnt;
    logic                  stop_cnt;
    ast_state_t            state;

    logic                  tx_buffer_empty_flag;

    // Decoded control fields
    logic transmitter_enable_bit;
    logic clocked_mode_sel;
    logic serial_port_enable;
    logic nine_bit_mode;
    logic tx_invert_select;
    logic tx_irq_mask;
    logic two_stop;

    assign transmitter_enable_bit = ctrl[AST_CTRL_TRANSMITTER_ENABLE_BIT];
    assign clocked_mode_sel       = ctrl[AST_CTRL_SYNC];
    assign serial_port_enable     = ctrl[AST_CTRL_SERIAL_PORT_ENABLE];
    assign nine_bit_mode          = ctrl[AST_CTRL_NINE];
    assign tx_invert_select       = ctrl[AST_CTRL_INV];
    assign tx_irq_mask            = ctrl[AST_CTRL_MASK];
    assign two_stop               = ctrl[AST_CTRL_STOP2];

    // Async transmission needs all three settings together
    logic async_active;
    assign async_active = transmitter_enable_bit && !clocked_mode_sel
                          && serial_port_enable;

    // APB decode
    logic setup_phase;
    logic wr_access;
    logic addr_hit;
    assign setup_phase = psel && !penable;
    assign wr_access   = psel && penable && pwrite;
    // No wait states: every access completes in its first access cycle
    assign pready      = psel && penable;

    always_comb begin
        if (paddr == AST_CTRL_OFS) begin
            addr_hit = 1'b1;
        end else if (paddr == AST_DATA_OFS) begin
            addr_hit = 1'b1;
        end else if (paddr == AST_STATUS_OFS) begin
            addr_hit = 1'b1;
        end else if (paddr == AST_BAUD_OFS) begin
            addr_hit = 1'b1;
        end else begin
            addr_hit = 1'b0;
        end
    end

    logic wr_ctrl;
    logic wr_data;
    logic wr_baud;
    assign wr_ctrl = wr_access && paddr == AST_CTRL_OFS;
    assign wr_baud = wr_access && paddr == AST_BAUD_OFS;
    // Characters written while disabled are dropped
    assign wr_data = wr_access && paddr == AST_DATA_OFS
                     && transmitter_enable_bit;

    // Baud generator link
    ast_baud_if baud ();
    logic       load_now;

    assign baud.divisor = baud_div;
    assign baud.brg16   = ctrl[AST_CTRL_BRG16];
    // Restart on every load so the start bit gets a full period
    assign baud.restart = load_now || !async_active;

    ast_baud_gen u_baud (
        .clk_sys (clk_sys),
        .reset   (reset),
        .ce      (ce),
        .baud    (baud)
    );

    // End of the last stop bit of the current frame
    logic frame_done;
    assign frame_done = state == AST_STOP && baud.tick
                        && (stop_cnt || !two_stop);

    // Shifter takes the buffer when idle or right after a stop bit
    assign load_now = async_active && hold_full
                      && (state == AST_IDLE || frame_done);

    logic [3:0] last_bit;
    assign last_bit = nine_bit_mode ? AST_LAST_BIT9 : AST_LAST_BIT8;

    // Control register; inversion resets to non-inverted
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl <= AST_CTRL_RST;
        end else if (ce && wr_ctrl) begin
            ctrl <= pwdata[AST_CTRL_W-1:0];
        end
    end

    // Baud divisor register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            baud_div <= AST_BAUD_RST;
        end else if (ce && wr_baud) begin
            baud_div <= pwdata[15:0];
        end
    end

    // Holding buffer: a write wins over a same-cycle transfer
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tx_holding_buffer <= '0;
            hold_full         <= 1'b0;
        end else if (ce) begin
            if (!transmitter_enable_bit) begin
                hold_full <= 1'b0;
            end else if (wr_data) begin
                tx_holding_buffer <= pwdata[AST_DATA_W-1:0];
                hold_full         <= 1'b1;
            end else if (load_now) begin
                hold_full <= 1'b0;
            end
        end
    end

    // Shifter state machine, stepping on baud ticks except idle to start, which follows a load
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state    <= AST_IDLE;
            bit_cnt  <= 4'h0;
            stop_cnt <= 1'b0;
        end else if (ce) begin
            if (!async_active) begin
                state <= AST_IDLE;
            end else begin
                case (state)
                    AST_IDLE: begin
                        if (load_now) begin
                            state <= AST_START;
                        end
                    end
                    AST_START: begin
                        if (baud.tick) begin
                            state   <= AST_DATA;
                            bit_cnt <= 4'h0;
                        end
                    end
                    AST_DATA: begin
                        if (baud.tick) begin
                            if (bit_cnt == last_bit) begin
                                state    <= AST_STOP;
                                stop_cnt <= 1'b0;
                            end else begin
                                bit_cnt <= bit_cnt + 4'h1;
                            end
                        end
                    end
                    AST_STOP: begin
                        if (frame_done) begin
                            // Back to back frames skip idle
                            state <= load_now ? AST_START
                                              : AST_IDLE;
                        end else if (baud.tick) begin
                            stop_cnt <= 1'b1;
                        end
                    end
                    default: begin
                        state <= AST_IDLE;
                    end
                endcase
            end
        end
    end

    // Shift register, loaded only from the holding buffer
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tx_shift_reg <= '0;
        end else if (ce) begin
            if (load_now) begin
                tx_shift_reg <= tx_holding_buffer;
            end else if (state == AST_DATA && baud.tick) begin
                tx_shift_reg <= {1'b0, tx_shift_reg[AST_DATA_W-1:1]};
            end
        end
    end

    // Unframed line level; mark whenever nothing is sent
    logic frame_level;
    always_comb begin
        case (state)
            AST_START: frame_level = AST_SPACE;
            AST_DATA:  frame_level = tx_shift_reg[0];
            default:   frame_level = AST_MARK;
        endcase
    end

    // Inversion only counts in async mode; the bit is reused otherwise
    logic inv_eff;
    assign inv_eff = tx_invert_select && !clocked_mode_sel;

    // Pin register delays the whole waveform evenly by one clock
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            transmit_line_pin  <= AST_MARK;
            transmit_line_oe_n <= 1'b1;
        end else if (ce) begin
            transmit_line_pin  <= frame_level ^ inv_eff;
            transmit_line_oe_n <= !serial_port_enable;
        end
    end

    // Empty flag follows buffer state one clock late, so it reads
    // valid on the second cycle after the write and never at once
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tx_buffer_empty_flag <= 1'b0;
        end else if (ce) begin
            tx_buffer_empty_flag <= transmitter_enable_bit
                && !(hold_full && state != AST_IDLE);
        end
    end

    // Request goes out only with the mask; the flag ignores it
    assign tx_irq_req = tx_buffer_empty_flag && tx_irq_mask;

    // Read data captured in the setup phase; status is read-only
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (ce && setup_phase) begin
            pslverr <= !addr_hit;
            prdata  <= 32'h0000_0000;
            if (!pwrite) begin
                if (paddr == AST_CTRL_OFS) begin
                    prdata[AST_CTRL_W-1:0] <= ctrl;
                end else if (paddr == AST_STATUS_OFS) begin
                    prdata[AST_STAT_EMPTY] <= tx_buffer_empty_flag;
                    prdata[AST_STAT_BUSY]  <= state != AST_IDLE;
                    prdata[AST_STAT_LINE]  <= transmit_line_pin;
                end else if (paddr == AST_BAUD_OFS) begin
                    prdata[15:0] <= baud_div;
                end
            end
        end
    end

endmodule : ast_transmitter

/* File: verif/ast_transmitter_asserts.sv */
`timescale 1ns/100ps
module ast_transmitter_asserts
    import ast_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        transmit_line_pin,
    input wire logic        transmit_line_oe_n,
    input wire logic        tx_irq_req
);
    logic [7:0]  ctl;
    logic [15:0] dv;
    int          quiet;
    int          lim;
    logic        wr;
    logic        dwr;
    logic        on;
    assign wr  = psel && penable && pwrite && ce;
    assign dwr = wr && paddr == AST_DATA_OFS;
    assign on  = ctl[AST_CTRL_TRANSMITTER_ENABLE_BIT] && ctl[AST_CTRL_SERIAL_PORT_ENABLE]
                 && !ctl[AST_CTRL_SYNC];
    // Two longest frames plus slack, so a queued pair has drained
    assign lim = 24 * (int'(dv) + 1) + 8;
    // Shadow of control and divisor
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctl <= AST_CTRL_RST;
            dv  <= AST_BAUD_RST;
        end else if (wr && paddr == AST_CTRL_OFS) begin
            ctl <= pwdata[7:0];
        end else if (wr && paddr == AST_BAUD_OFS) begin
            dv  <= pwdata[15:0];
        end
    end
    // Cycles since any write that may start or reshape a frame
    always_ff @(posedge clk_sys) begin
        if (reset || (wr && paddr != AST_STATUS_OFS)) begin
            quiet <= 0;
        end else if (quiet < 100000) begin
            quiet <= quiet + 1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    idle_level_a: assert property (
        on && quiet > lim |-> transmit_line_pin == !ctl[AST_CTRL_INV])
        else $error("line not idle at mark");
    start_bit_a: assert property (
        dwr && on && quiet > lim
        |-> ##3 transmit_line_pin == ctl[AST_CTRL_INV])
        else $error("start bit late or wrong level");
    oe_pin_a: assert property (
        $stable(ctl[AST_CTRL_SERIAL_PORT_ENABLE])
        |-> transmit_line_oe_n == !ctl[AST_CTRL_SERIAL_PORT_ENABLE])
        else $error("pin enable does not follow port enable");
    flag_on_a: assert property (
        wr && paddr == AST_CTRL_OFS && pwdata[AST_CTRL_TRANSMITTER_ENABLE_BIT]
        && pwdata[AST_CTRL_MASK] && !ctl[AST_CTRL_TRANSMITTER_ENABLE_BIT] |-> ##2 tx_irq_req)
        else $error("empty flag not set by enable");
    idle_irq_a: assert property (
        on && quiet > lim |-> tx_irq_req == ctl[AST_CTRL_MASK])
        else $error("idle request differs from mask");
    irq_gate_a: assert property (
        tx_irq_req |-> ctl[AST_CTRL_MASK])
        else $error("request without mask");
    flag_hold_a: assert property (
        dwr && tx_irq_req |=> tx_irq_req)
        else $error("empty flag cleared too early");
    data_rd_a: assert property (
        psel && penable && !pwrite && paddr == AST_DATA_OFS |-> prdata == '0)
        else $error("holding buffer readable");
endmodule : ast_transmitter_asserts
bind ast_transmitter ast_transmitter_asserts u_chk (
    .clk_sys(clk_sys), .reset(reset), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .transmit_line_pin(transmit_line_pin),
    .transmit_line_oe_n(transmit_line_oe_n), .tx_irq_req(tx_irq_req));

/* File: verif/ast_rx_model.sv */
`timescale 1ns/100ps
module ast_rx_model (
    input  wire logic        clk_sys,
    input  wire logic        line,
    input  wire logic        on,
    input  wire logic        inv,
    input  wire logic        nine,
    input  wire logic [16:0] bit_len,
    output logic      [8:0]  rx_word,
    output logic             rx_stop,
    output logic      [7:0]  rx_count
);
    logic [8:0] w;
    initial begin
        rx_word  = 9'h000;
        rx_stop  = 1'b0;
        rx_count = 8'h00;
    end
    // Start edge, then mid-bit samples; off while mode changes
    always begin
        @(posedge clk_sys);
        if (on && (line ^ inv) == 1'b0) begin
            w = 9'h000;
            repeat (bit_len / 2) @(posedge clk_sys);
            for (int i = 0; i < (nine ? 9 : 8); i++) begin
                repeat (bit_len) @(posedge clk_sys);
                w[i] = line ^ inv;
            end
            repeat (bit_len) @(posedge clk_sys);
            // Outputs settle after the edge so the bench never races them
            rx_stop  <= line ^ inv;
            rx_word  <= w;
            rx_count <= rx_count + 8'h01;
        end
    end
endmodule : ast_rx_model

/* File: verif/ast_transmitter_test.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
    fails++; $display("Error at %0t: mismatch", $time); end end
module ast_transmitter_test;
    import ast_pkg::*;
    localparam int DIV = 3;
    localparam int LIMIT = 6000;
    localparam logic [31:0] CTL [4] = '{32'h05, 32'h0D, 32'h15, 32'h1D};
    localparam logic [31:0] DAT [4] = '{32'h1A5, 32'h15B, 32'h0C3, 32'h10F};
    logic        clk_sys, reset, ce, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, pin, oe_n, irq, err, on, inv, nine;
    logic [8:0]  rx_word, exp_word;
    logic        rx_stop;
    logic [7:0]  rx_count, n;
    int          fails, samples_checked, cyc, k, t1;
    ast_transmitter u_dut (
        .clk_sys(clk_sys), .reset(reset), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .transmit_line_pin(pin),
        .transmit_line_oe_n(oe_n), .tx_irq_req(irq));
    ast_rx_model u_rx (
        .clk_sys(clk_sys), .line(pin), .on(on), .inv(inv), .nine(nine),
        .bit_len(17'(DIV + 1)), .rx_word(rx_word), .rx_stop(rx_stop),
        .rx_count(rx_count));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Hang guard
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            fails++;
            $display("Error at %0t: timeout", $time);
            finish_test();
        end
    end
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic check_rx(input logic [31:0] d);
        n = n + 8'h01;
        while (rx_count !== n) @(posedge clk_sys);
        exp_word = nine ? d[8:0] : {1'b0, d[7:0]};
        `CHK(rx_word, exp_word)
        `CHK(rx_stop, 1'b1)
    endtask : check_rx
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    initial begin
        reset   = 1'b1;
        ce      = 1'b1;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        on      = 1'b0;
        inv     = 1'b0;
        nine    = 1'b0;
        n       = 8'h00;
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        // Reset values, divisor, unmapped and hidden registers
        apb(1'b0, AST_CTRL_OFS, 32'h0);
        `CHK(q, 32'h0)
        apb(1'b1, AST_BAUD_OFS, 32'(DIV));
        apb(1'b1, 12'h010, 32'hFFFF_FFFF);
        `CHK(err, 1'b1)
        apb(1'b0, AST_DATA_OFS, 32'h0);
        `CHK(q, 32'h0)
        // Enable with mask; status write must not clear the flag
        apb(1'b1, AST_CTRL_OFS, 32'h25);
        apb(1'b1, AST_STATUS_OFS, 32'h0);
        apb(1'b0, AST_STATUS_OFS, 32'h0);
        `CHK(q[AST_STAT_EMPTY], 1'b1)
        `CHK(irq, 1'b1)
        `CHK(oe_n, 1'b0)
        // Every width and polarity; start bit width measured
        for (int i = 0; i < 4; i++) begin
            on <= 1'b0;
            apb(1'b1, AST_CTRL_OFS, CTL[i]);
            inv  <= CTL[i][AST_CTRL_INV];
            nine <= CTL[i][AST_CTRL_NINE];
            repeat (120) @(posedge clk_sys);
            on <= 1'b1;
            `CHK(irq, 1'b0)
            apb(1'b1, AST_DATA_OFS, DAT[i]);
            k = 0;
            while (pin !== inv) @(posedge clk_sys);
            while (pin === inv) begin
                k++;
                @(posedge clk_sys);
            end
            `CHK(k, DIV + 1)
            check_rx(DAT[i]);
        end
        // Queued character follows the stop bit directly
        on <= 1'b0;
        apb(1'b1, AST_CTRL_OFS, 32'h25);
        inv  <= 1'b0;
        nine <= 1'b0;
        repeat (120) @(posedge clk_sys);
        on <= 1'b1;
        apb(1'b1, AST_DATA_OFS, 32'h3C);
        apb(1'b1, AST_DATA_OFS, 32'hA5);
        apb(1'b1, AST_CTRL_OFS, 32'h05);
        apb(1'b0, AST_STATUS_OFS, 32'h0);
        `CHK(q[AST_STAT_EMPTY], 1'b0)
        check_rx(32'h3C);
        t1 = cyc;
        check_rx(32'hA5);
        `CHK(cyc - t1, 10 * (DIV + 1))
        apb(1'b0, AST_STATUS_OFS, 32'h0);
        `CHK(q[AST_STAT_EMPTY], 1'b1)
        `CHK(irq, 1'b0)
        // Two stop bits; eight-bit mode ignores the upper divisor byte
        apb(1'b1, AST_BAUD_OFS, 32'h100 + 32'(DIV));
        apb(1'b1, AST_CTRL_OFS, 32'h85);
        apb(1'b1, AST_DATA_OFS, 32'h96);
        apb(1'b1, AST_DATA_OFS, 32'h69);
        check_rx(32'h96);
        t1 = cyc;
        check_rx(32'h69);
        `CHK(cyc - t1, 11 * (DIV + 1))
        // Sixteen-bit divider with the same short period
        apb(1'b1, AST_BAUD_OFS, 32'(DIV));
        apb(1'b1, AST_CTRL_OFS, 32'hC5);
        apb(1'b1, AST_DATA_OFS, 32'h5A);
        check_rx(32'h5A);
        // Clocked mode sends nothing and leaves the line uninverted
        apb(1'b1, AST_CTRL_OFS, 32'h17);
        apb(1'b1, AST_DATA_OFS, 32'h55);
        repeat (80) @(posedge clk_sys);
        `CHK(rx_count, n)
        `CHK(pin, 1'b1)
        // Without the transmitter enable nothing is sent
        apb(1'b1, AST_CTRL_OFS, 32'h04);
        apb(1'b1, AST_DATA_OFS, 32'h55);
        repeat (80) @(posedge clk_sys);
        `CHK(rx_count, n)
        finish_test();
    end
endmodule : ast_transmitter_test
